// *** design/usp_top.sv ***
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
module usp_top
  import usp_pkg::*;
(
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  input  wire logic        RXD_IN,
  input  wire logic        TXD_IN,
  output logic             TXD_OUT,
  output logic             TXD_OE_OUT,
  output logic             ERR_IRQ_OUT
);
  typedef struct packed {
    logic        ack;   // Bus acknowledge
    logic [31:0] rdat;  // Registered read data
    logic [12:0] baud;  // Baud divisor
    logic [7:0]  ctrl;  // Own control bits
    logic [7:0]  ctl3;  // control_three
    logic [7:0]  rxbuf; // Receive half of data_buffer
    logic [7:0]  txbuf; // Transmit half of data_buffer
    logic        full;  // rx_full_flag
    logic        ovr;   // Overrun flag
    logic        nf;    // noise_flag
    logic        fe;    // framing_error_flag
    logic        pf;    // parity_error_flag
    logic        tdre;  // Transmit buffer empty
    logic        tc;    // Transmit complete
    logic        arm;   // Status read with flags set
    usp_tx_e     txst;  // Transmitter state
    logic [10:0] txsh;  // Transmit shifter
    logic [3:0]  txcnt; // Bits left in frame
    logic [3:0]  txph;  // Phase within bit
    logic        txd;   // Pin level, after inversion
    logic        oe;    // Pin drive enable
    logic        irq;   // Error request
    logic        rx_s1; // Receive pin sync stages
    logic        rx_s2;
    logic        tp_s1; // Transmit pin sync stages
    logic        tp_s2;
  } usp_top_s;
  usp_top_s r, n;

  usp_link_if lk ();

  logic       req;      // New bus request this cycle
  logic       wr;       // Write request
  logic       rd;       // Read request
  logic       tx_load;  // Buffer moves to shifter
  logic       errs_any; // Enabled flag present
  logic       sw_mode;  // Single-wire mode
  logic       pe_bit;   // Parity check result
  logic [8:0] tx9;      // Character to send
  logic [7:0] stat;     // Status image

  usp_baud #(
    .W (BAUD_W)
  ) u_baud (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (RESET_N_IN),
    .div_in   (r.baud),
    .lk       (lk.gen)
  );

  usp_rx u_rx (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (RESET_N_IN),
    .lk       (lk.rxp)
  );

  // Receiver source: pin, own transmitter, or shared pin
  assign sw_mode = r.ctrl[CTL_LOOP] & r.ctrl[CTL_RECEIVE_SOURCE_SELECT];
  assign lk.nine = r.ctrl[CTL_NINE];
  assign lk.line = ~r.ctrl[CTL_LOOP] ? r.rx_s2
                 : (r.ctrl[CTL_RECEIVE_SOURCE_SELECT] ? r.tp_s2
                 : r.txd ^ r.ctl3[C3_INV]);

  // Enabled error flags merged into one request
  assign errs_any = (r.ovr & r.ctl3[C3_OVERRUN_IRQ_EN])
                  | (r.nf & r.ctl3[C3_NOISE_IRQ_EN])
                  | (r.fe & r.ctl3[C3_FRAMING_IRQ_EN])
                  | (r.pf & r.ctl3[C3_PARITY_IRQ_EN]);

  // Main next-state logic
  always_comb begin
    n = r;
    req = WB_CYC_IN & WB_STB_IN & ~r.ack;
    wr = req & WB_WE_IN;
    rd = req & ~WB_WE_IN;
    tx_load = 1'b0;
    // Pin synchronisers; only second stages are read
    n.rx_s1 = RXD_IN;
    n.rx_s2 = r.rx_s1;
    n.tp_s1 = TXD_IN;
    n.tp_s2 = r.tp_s1;
    // Status image
    stat = '0;
    stat[ST_PF] = r.pf;
    stat[ST_FE] = r.fe;
    stat[ST_NF] = r.nf;
    stat[ST_OR] = r.ovr;
    stat[ST_FULL] = r.full;
    stat[ST_TC] = r.tc;
    stat[ST_TDRE] = r.tdre;
    // Single-cycle answer; unmapped reads give zero
    n.ack = req;
    n.rdat = '0;
    if (rd) begin
      unique case (WB_ADR_IN)
        OFS_BAUD: n.rdat = {19'h00000, r.baud};
        OFS_CTRL: n.rdat = {24'h000000, r.ctrl};
        OFS_STAT: n.rdat = {24'h000000, stat};
        OFS_CTL3: n.rdat = {24'h000000, r.ctl3};
        OFS_DATA: n.rdat = {24'h000000, r.rxbuf};
        default:  n.rdat = '0;
      endcase
    end
    // Flag clearing: status read arms, data read clears
    if (rd && WB_ADR_IN == OFS_STAT) begin
      n.arm = r.full | r.ovr | r.nf | r.fe | r.pf;
    end
    if (rd && WB_ADR_IN == OFS_DATA && r.arm) begin
      n.arm = 1'b0;
      n.full = 1'b0;
      n.ovr = 1'b0;
      n.nf = 1'b0;
      n.fe = 1'b0;
      n.pf = 1'b0;
    end
    // Register writes, low lanes only
    if (wr && WB_ADR_IN == OFS_BAUD) begin
      if (WB_SEL_IN[0]) n.baud[7:0] = WB_DAT_IN[7:0];
      if (WB_SEL_IN[1]) n.baud[12:8] = WB_DAT_IN[12:8];
    end
    if (wr && WB_SEL_IN[0]) begin
      if (WB_ADR_IN == OFS_CTRL) begin
        n.ctrl = WB_DAT_IN[7:0];
      end
      if (WB_ADR_IN == OFS_CTL3) begin
        // Received ninth bit is read only
        n.ctl3[6:0] = WB_DAT_IN[6:0];
      end
      if (WB_ADR_IN == OFS_DATA) begin
        n.txbuf = WB_DAT_IN[7:0];
        n.tdre = 1'b0;
        n.tc = 1'b0;
      end
    end
    // Received character hand-over; set beats clear
    pe_bit = (lk.nine ? ^lk.data : ^lk.data[7:0])
           ^ r.ctrl[CTL_PT];
    if (lk.done && r.ctrl[CTL_RE]) begin
      if (r.full) begin
        n.ovr = 1'b1;
      end else if (!r.fe) begin
        // A held framing error blocks new characters
        n.rxbuf = lk.data[7:0];
        n.ctl3[C3_R8] = lk.data[8];
        n.full = 1'b1;
        n.fe = lk.ferr;
        n.nf = lk.noise;
        n.pf = r.ctrl[CTL_PE] & pe_bit;
      end
    end
    // Character to send; ninth bit is not cleared here
    tx9 = {r.ctl3[C3_T8], r.txbuf};
    if (r.ctrl[CTL_PE]) begin
      if (r.ctrl[CTL_NINE]) begin
        tx9[8] = ^r.txbuf ^ r.ctrl[CTL_PT];
      end else begin
        tx9[7] = ^r.txbuf[6:0] ^ r.ctrl[CTL_PT];
      end
    end
    // Transmitter, stepped by the shared baud tick
    unique case (r.txst)
      TX_IDLE: begin
        if (r.ctrl[CTL_TE] && !r.tdre) begin
          tx_load = 1'b1;
        end
      end
      TX_SHIFT: begin
        if (lk.tick16) begin
          n.txph = r.txph + 4'h1;
          if (r.txph == PH_LAST) begin
            n.txsh = {1'b1, r.txsh[10:1]};
            n.txcnt = r.txcnt - 4'h1;
            if (r.txcnt == 4'h1) begin
              n.txst = TX_IDLE;
              n.tc = r.tdre;
              tx_load = r.ctrl[CTL_TE] & ~r.tdre;
            end
          end
        end
      end
    endcase
    if (tx_load) begin
      // Whole frame built at once after the data write
      n.txst = TX_SHIFT;
      n.tdre = 1'b1;
      n.txph = '0;
      n.tc = 1'b0;
      if (r.ctrl[CTL_NINE]) begin
        n.txsh = {1'b1, tx9, 1'b0};
        n.txcnt = TXN9;
      end else begin
        n.txsh = {2'b11, tx9[7:0], 1'b0};
        n.txcnt = TXN8;
      end
    end
    // Pin level and direction, registered
    n.txd = (n.txst == TX_SHIFT ? n.txsh[0] : 1'b1)
          ^ n.ctl3[C3_INV];
    n.oe = sw_mode ? n.ctl3[C3_DIR] : 1'b1;
    n.irq = errs_any;
  end

  // State register
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      r <= '0;
      r.baud <= BAUD_RST;
      r.ctrl <= CTRL_RST;
      r.ctl3 <= CTL3_RST;
      r.rxbuf <= DATA_RST;
      r.txbuf <= DATA_RST;
      r.tdre <= 1'b1;
      r.tc <= 1'b1;
      r.txst <= TX_IDLE;
      r.txd <= 1'b1;
      r.oe <= 1'b1;
      r.rx_s1 <= 1'b1;
      r.rx_s2 <= 1'b1;
      r.tp_s1 <= 1'b1;
      r.tp_s2 <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign WB_DAT_OUT  = r.rdat;
  assign WB_ACK_OUT  = r.ack;
  assign TXD_OUT     = r.txd;
  assign TXD_OE_OUT  = r.oe;
  assign ERR_IRQ_OUT = r.irq;

  AST_IRQ_OR: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    1'b1 |=> ERR_IRQ_OUT == $past(errs_any))
    else $error("error request does not follow flags");

  AST_IDLE_POL: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (r.txst == TX_IDLE && !tx_load) |=>
      TXD_OUT == ~r.ctl3[C3_INV])
    else $error("idle level ignores inversion");

  AST_OVERRUN: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (lk.done && r.ctrl[CTL_RE] && r.full) |=>
      r.ovr && $stable(r.rxbuf))
    else $error("overrun not flagged or data replaced");

  AST_FRAMING: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (lk.done && r.ctrl[CTL_RE] && !r.full && !r.fe && lk.ferr)
      |=> r.fe && r.full)
    else $error("framing error not set with full flag");

  AST_RX_NINTH: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (lk.done && r.ctrl[CTL_RE] && !r.full && !r.fe && lk.nine)
      |=> r.ctl3[C3_R8] == $past(lk.data[8]))
    else $error("received ninth bit not captured");

  AST_T8_KEPT: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (wr && WB_ADR_IN == OFS_DATA) |=> $stable(r.ctl3[C3_T8]))
    else $error("data write disturbed transmit ninth bit");

  AST_T9_LOAD: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (tx_load && r.ctrl[CTL_NINE] && !r.ctrl[CTL_PE]) |=>
      r.txsh[9] == $past(r.ctl3[C3_T8]) && r.txcnt == TXN9)
    else $error("ninth bit not loaded into shifter");

  AST_PIN_DIR: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (sw_mode && !wr) |=> TXD_OE_OUT == $past(r.ctl3[C3_DIR]))
    else $error("single-wire direction not applied");

  AST_DATA_CLR: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (rd && WB_ADR_IN == OFS_DATA && r.arm && !lk.done) |=>
      !r.full && !r.fe && !r.ovr)
    else $error("data read did not clear flags");

  // Each enabled flag must reach the request one clock later
  AST_OVR_REQ: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (r.ovr && r.ctl3[C3_OVERRUN_IRQ_EN]) |=> ERR_IRQ_OUT)
    else $error("enabled overrun raised no request");

  AST_NOISE_REQ: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (r.nf && r.ctl3[C3_NOISE_IRQ_EN]) |=> ERR_IRQ_OUT)
    else $error("enabled noise flag raised no request");

  AST_FRAME_REQ: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (r.fe && r.ctl3[C3_FRAMING_IRQ_EN]) |=> ERR_IRQ_OUT)
    else $error("enabled framing flag raised no request");

  AST_PAR_REQ: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (r.pf && r.ctl3[C3_PARITY_IRQ_EN]) |=> ERR_IRQ_OUT)
    else $error("enabled parity flag raised no request");

  // With every enable off, flags are left to polling
  AST_IRQ_MASKED: assert property (
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (r.ctl3[C3_OVERRUN_IRQ_EN:C3_PARITY_IRQ_EN] == 4'h0) |=> !ERR_IRQ_OUT)
    else $error("request raised with all enables off");
endmodule

// *** design/usp_pkg.sv ***
package usp_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_BAUD = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_CTL3 = 8'h0C;
  localparam logic [7:0] OFS_DATA = 8'h10;
  // Control register fields
  localparam int CTL_TE   = 0;
  localparam int CTL_RE   = 1;
  localparam int CTL_NINE = 2;
  localparam int CTL_PE   = 3;
  localparam int CTL_PT   = 4;
  localparam int CTL_LOOP = 5;
  localparam int CTL_RECEIVE_SOURCE_SELECT = 6;
  // Status register fields
  localparam int ST_PF   = 0;
  localparam int ST_FE   = 1;
  localparam int ST_NF   = 2;
  localparam int ST_OR   = 3;
  localparam int ST_FULL = 5;
  localparam int ST_TC   = 6;
  localparam int ST_TDRE = 7;
  // Control three fields
  localparam int C3_PARITY_IRQ_EN = 0;
  localparam int C3_FRAMING_IRQ_EN = 1;
  localparam int C3_NOISE_IRQ_EN = 2;
  localparam int C3_OVERRUN_IRQ_EN = 3;
  localparam int C3_INV  = 4;
  localparam int C3_DIR  = 5;
  localparam int C3_T8   = 6;
  localparam int C3_R8   = 7;
  // Baud divisor width and reset values
  localparam int          BAUD_W   = 13;
  localparam logic [12:0] BAUD_RST = 13'h001B;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  CTL3_RST = 8'h00;
  localparam logic [7:0]  DATA_RST = 8'h00;
  // Oversampling phases within one bit time
  localparam logic [3:0] SMP_A    = 4'h7;
  localparam logic [3:0] SMP_C    = 4'h9;
  localparam logic [3:0] PH_STOP  = 4'hA;
  localparam logic [3:0] PH_LAST  = 4'hF;
  // Receive stop index and transmit frame lengths
  localparam logic [3:0] STOP8 = 4'h9;
  localparam logic [3:0] STOP9 = 4'hA;
  localparam logic [3:0] TXN8  = 4'hA;
  localparam logic [3:0] TXN9  = 4'hB;
  // Transmitter states
  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} usp_tx_e;
endpackage

// *** design/usp_link_if.sv ***
interface usp_link_if;
  logic       tick16; // One pulse per sixteenth of a bit
  logic       line;   // Selected receive line level
  logic       nine;   // Nine data bits per character
  logic       done;   // Character complete pulse
  logic       ferr;   // Stop bit sampled low
  logic       noise;  // Some sample disagreed
  logic [8:0] data;   // Received bits, right aligned
  modport gen  (output tick16);
  modport rxp  (input tick16, line, nine,
                output done, ferr, noise, data);
  modport core (input tick16, done, ferr, noise, data,
                output line, nine);
endinterface

// *** design/usp_baud.sv ***
module usp_baud
  import usp_pkg::*;
#(
  parameter int W = BAUD_W
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] div_in,
  usp_link_if.gen           lk
);
  typedef struct packed {
    logic [W-1:0] cnt;  // Modulo counter
    logic         tick; // Registered tick
  } usp_baud_s;
  usp_baud_s r, n;

  // Modulo divider; a zero divisor parks the generator
  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (div_in == '0) begin
      n.cnt = '0;
    end else if (r.cnt >= div_in - 1'b1) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lk.tick16 = r.tick;

  AST_TICK_WRAP: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    r.tick |-> r.cnt == '0)
    else $error("baud tick without counter wrap");
endmodule

// *** design/usp_rx.sv ***
module usp_rx
  import usp_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  usp_link_if.rxp   lk
);
  typedef struct packed {
    logic       busy;  // Inside a frame
    logic [3:0] ph;    // Phase within bit
    logic [3:0] idx;   // Bit index, start is 0
    logic [2:0] smp;   // Three mid-bit samples
    logic [8:0] sh;    // Data shifter, lsb first
    logic       prev;  // Previous line sample
    logic       nz;    // Noise seen so far
    logic       done;
    logic       ferr;
    logic       noise;
  } usp_rx_s;
  usp_rx_s r, n;
  logic fall;  // Falling edge on this tick
  logic bitv;  // Majority value of the bit
  logic bnz;   // Samples of this bit disagree
  logic [3:0] stop_idx;

  // Frame tracking with resync on falling edges
  always_comb begin
    n = r;
    n.done = 1'b0;
    fall = r.prev & ~lk.line;
    bitv = (r.smp[0] & r.smp[1]) | (r.smp[0] & r.smp[2])
         | (r.smp[1] & r.smp[2]);
    bnz = (r.smp != 3'b000) && (r.smp != 3'b111);
    stop_idx = lk.nine ? STOP9 : STOP8;
    if (lk.tick16) begin
      n.prev = lk.line;
      if (!r.busy) begin
        // Wait for a start edge
        if (fall) begin
          n.busy = 1'b1;
          n.ph = '0;
          n.idx = '0;
          n.nz = 1'b0;
        end
      end else begin
        n.ph = r.ph + 4'h1;
        if (r.ph >= SMP_A && r.ph <= SMP_C) begin
          n.smp = {r.smp[1:0], lk.line};
        end
        if (r.idx == stop_idx && r.ph == PH_STOP) begin
          // Close early so the next start edge is seen
          n.busy = 1'b0;
          n.done = 1'b1;
          n.ferr = ~bitv;
          n.noise = r.nz | bnz;
        end else if (r.ph == PH_LAST || (fall && r.ph > SMP_C)) begin
          n.ph = '0;
          n.idx = r.idx + 4'h1;
          n.nz = r.nz | bnz;
          if (r.idx == '0 && bitv) begin
            n.busy = 1'b0; // False start, treat as noise
          end else if (r.idx != '0) begin
            n.sh = {bitv, r.sh[8:1]};
          end
        end
      end
    end
  end

  // State register; line idles high
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      r <= '0;
      r.prev <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign lk.done  = r.done;
  assign lk.ferr  = r.ferr;
  assign lk.noise = r.noise;
  assign lk.data  = lk.nine ? r.sh : {1'b0, r.sh[8:1]};

  AST_RESYNC: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (lk.tick16 && r.busy && fall && r.ph > SMP_C
      && r.idx != stop_idx) |=> r.ph == '0)
    else $error("no resync on falling edge");
endmodule

// *** tb/usp_remote.sv ***
// Remote serial party beside the port: sends frames onto the device
// receive pin and decodes frames from the device transmit pin.
module usp_remote (
  input  wire logic clk_in,   // Bench clock
  input  wire logic line_in,  // Device transmit wire
  output logic      line_out  // Device receive wire, idles high
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line idles at mark level like a pulled-up wire
  initial begin
    line_out = 1'b1;
  end

  // One frame, lsb first; bclk sets our own rate, kept near the device
  task automatic send(input logic [8:0] d, input int nb,
                      input logic stop_v, input int bclk);
    for (int i = -1; i <= nb; i++) begin
      @(posedge clk_in);
      line_out <= (i < 0) ? 1'b0 : ((i == nb) ? stop_v : d[i]);
      repeat (bclk - 1) @(posedge clk_in);
    end
    // One idle bit so a low stop bit still ends on mark
    @(posedge clk_in);
    line_out <= 1'b1;
    repeat (bclk - 1) @(posedge clk_in);
  endtask

  // Zero frame with a two-clock spike mid data bit 3; one sample
  // of three is hit, so the value holds but noise is flagged
  task automatic spike(input int bclk);
    @(posedge clk_in);
    line_out <= 1'b0;
    repeat (4 * bclk + 17) @(posedge clk_in);
    line_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    line_out <= 1'b0;
    repeat (5 * bclk - 19) @(posedge clk_in);
    line_out <= 1'b1;
    repeat (2 * bclk) @(posedge clk_in);
  endtask

  // Wait for a start bit, then sample each bit in its middle
  task automatic get(input int nb, input logic inv, input int bclk,
                     output logic [8:0] d, output logic ok);
    int n;
    n = 0;
    d = 9'h000;
    while (((line_in ^ inv) !== 1'b0) && (n < 5000)) begin
      @(posedge clk_in);
      n++;
    end
    ok = (n < 5000);
    repeat (bclk / 2) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      repeat (bclk) @(posedge clk_in);
      d[i] = line_in ^ inv;
    end
    // Stop bit must read as mark after inversion is undone
    repeat (bclk) @(posedge clk_in);
    ok = ok && ((line_in ^ inv) === 1'b1);
  endtask
endmodule

// *** tb/usp_top_tb.sv ***
// Register-level bench: bus cycles, serial frames, error requests
module usp_top_tb;
  import usp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BCLK = 32; // Clocks per bit with divisor 2
  // Error cases: parity, framing, overrun, noise
  localparam logic [7:0] CT [4] = '{8'h0B, 8'h03, 8'h03, 8'h03};
  localparam logic [7:0] EN [4] = '{8'h01, 8'h02, 8'h08, 8'h04};
  localparam logic [7:0] ST [4] = '{8'hE1, 8'hE2, 8'hE8, 8'hE4};
  localparam logic [7:0] DT [4] = '{8'h01, 8'h55, 8'h11, 8'h00};

  logic        ref_clk;     // Bench clock
  logic        rst_n;       // Synchronous reset, active low
  logic        cyc;         // Bus cycle
  logic        stb;         // Bus strobe
  logic        we;          // Bus write
  logic [3:0]  sel;         // Byte lanes
  logic [7:0]  adr;         // Byte address
  logic [31:0] wdat;        // Write data
  logic [31:0] rdat;        // Read data
  logic        ack;         // Bus answer
  logic        rxd;         // Remote to device
  logic        txd;         // Device transmit level
  logic        txd_oe;      // Device drives the wire
  logic        txd_wire;    // Resolved transmit wire
  logic        irq;         // Error request
  logic [31:0] q;           // Last read value
  logic [8:0]  d;           // Frame seen by the remote
  logic        ok;          // Frame shape good
  int          errors;      // Mismatch count
  int          checks_done; // Comparison count

  // Wire is pulled up whenever the device lets go of it
  assign txd_wire = txd_oe ? txd : 1'b1;

  usp_top dut (
    .REF_CLK_IN  (ref_clk),
    .RESET_N_IN  (rst_n),
    .WB_CYC_IN   (cyc),
    .WB_STB_IN   (stb),
    .WB_WE_IN    (we),
    .WB_SEL_IN   (sel),
    .WB_ADR_IN   (adr),
    .WB_DAT_IN   (wdat),
    .WB_DAT_OUT  (rdat),
    .WB_ACK_OUT  (ack),
    .RXD_IN      (rxd),
    .TXD_IN      (txd_wire),
    .TXD_OUT     (txd),
    .TXD_OE_OUT  (txd_oe),
    .ERR_IRQ_OUT (irq)
  );

  usp_remote remote (
    .clk_in   (ref_clk),
    .line_in  (txd_wire),
    .line_out (rxd)
  );

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Word compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single pin compare
  task automatic chkb(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle: hold until ack is sampled, then one idle cycle;
  // a slave that never answers is left to the watchdog
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] v, output logic [31:0] r);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= 4'hF;
    adr  <= a;
    wdat <= v;
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    wb(1'b1, a, v, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask

  // Sole exit of the run
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", checks_done, errors);
    if ((errors == 0) && (checks_done > 0)) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard, about five times the expected run
  initial begin
    repeat (22000) @(posedge ref_clk);
    errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'hF;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    errors = 0;
    checks_done = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    chkb(txd, 1'b1);
    chkb(irq, 1'b0);
    rdc(OFS_CTL3, 32'h0000_0000);
    rdc(OFS_DATA, 32'h0000_0000);
    rdc(8'h20, 32'h0000_0000);
    // Received ninth bit is read-only
    wr(OFS_CTL3, 32'h0000_00FF);
    rdc(OFS_CTL3, 32'h0000_007F);
    wr(OFS_CTL3, 32'h0000_0010);
    chkb(txd, 1'b0);
    wr(OFS_BAUD, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0003);
    wr(OFS_DATA, 32'h0000_003C);
    remote.get(8, 1'b1, BCLK, d, ok);
    chk({23'h0, d}, 32'h0000_003C);
    chkb(ok, 1'b1);
    wr(OFS_CTL3, 32'h0000_0000);
    chkb(txd, 1'b1);
    wr(OFS_DATA, 32'h0000_00A5);
    remote.get(8, 1'b0, BCLK, d, ok);
    chk({23'h0, d}, 32'h0000_00A5);
    rdc(OFS_DATA, 32'h0000_0000);
    // Nine-bit: ninth bit set once, kept for the next character
    wr(OFS_CTRL, 32'h0000_0007);
    wr(OFS_CTL3, 32'h0000_0040);
    wr(OFS_DATA, 32'h0000_0055);
    remote.get(9, 1'b0, BCLK, d, ok);
    chk({23'h0, d}, 32'h0000_0155);
    wr(OFS_DATA, 32'h0000_000F);
    remote.get(9, 1'b0, BCLK, d, ok);
    chk({23'h0, d}, 32'h0000_010F);
    // Slightly fast remote; ninth bit fetched before the data
    remote.send(9'h1C3, 9, 1'b1, BCLK - 1);
    repeat (4) @(posedge ref_clk);
    rdc(OFS_CTL3, 32'h0000_00C0);
    rdc(OFS_STAT, 32'h0000_00E0);
    rdc(OFS_DATA, 32'h0000_00C3);
    rdc(OFS_STAT, 32'h0000_00C0);
    // Each error first with its enable off, then enabled
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CTRL, {24'h0, CT[k]});
      wr(OFS_CTL3, 32'h0000_0000);
      if (k == 3) begin
        remote.spike(BCLK);
      end else begin
        remote.send({1'b0, DT[k]}, 8, (k != 1), BCLK);
      end
      if (k == 2) begin
        remote.send(9'h022, 8, 1'b1, BCLK);
      end
      repeat (4) @(posedge ref_clk);
      chkb(irq, 1'b0);
      wr(OFS_CTL3, {24'h0, EN[k]});
      chkb(irq, 1'b1);
      rdc(OFS_STAT, {24'h0, ST[k]});
      rdc(OFS_DATA, {24'h0, DT[k]});
      chkb(irq, 1'b0);
      rdc(OFS_STAT, 32'h0000_00C0);
    end
    // Single-wire: bit 5 turns the pin around, receiver hears it
    wr(OFS_CTRL, 32'h0000_0063);
    wr(OFS_CTL3, 32'h0000_0000);
    chkb(txd_oe, 1'b0);
    wr(OFS_CTL3, 32'h0000_0020);
    chkb(txd_oe, 1'b1);
    wr(OFS_DATA, 32'h0000_005A);
    remote.get(8, 1'b0, BCLK, d, ok);
    repeat (BCLK) @(posedge ref_clk);
    rdc(OFS_STAT, 32'h0000_00E0);
    rdc(OFS_DATA, 32'h0000_005A);
    // Internal loop: receiver hears its own transmitter
    wr(OFS_CTRL, 32'h0000_0023);
    wr(OFS_DATA, 32'h0000_0096);
    repeat (12 * BCLK) @(posedge ref_clk);
    rdc(OFS_DATA, 32'h0000_0096);
    wrap_up();
  end
endmodule
